// ---- gpwm_pkg.sv ----
// constants, register map and bus carrier types for the gpio port with wake monitor
// assumes one 100 MHz clock and a classic wishbone master with 32-bit data
package gpwm_pkg;

    // ************************************************
    // geometry and timing
    // ************************************************
    localparam int NPIN              = 17;
    localparam int NLOW              = 16;
    localparam int NIRQ              = 4;
    localparam int CLK_NS            = 10;
    // unfiltered capture: one clock sample already covers this width
    localparam int UNF_MIN_NS        = 80;
    localparam int UNF_MIN_CYC       = (UNF_MIN_NS / CLK_NS < 1) ? 1 : UNF_MIN_NS / CLK_NS;
    localparam int FILT_MIN_NS       = 450;
    localparam int FILT_CYC          = (FILT_MIN_NS / CLK_NS < 1) ? 1 : FILT_MIN_NS / CLK_NS;
    localparam logic [5:0] FILT_LAST = 6'(FILT_CYC - 1);

    // pins that feed the four external interrupt lines a..d
    localparam int IRQ_PIN_A         = 8;
    localparam int IRQ_PIN_B         = 14;
    localparam int IRQ_PIN_C         = 15;
    localparam int IRQ_PIN_D         = 16;

    // ************************************************
    // register byte offsets
    // ************************************************
    localparam logic [7:0] ADR_LVL_L  = 8'h00;
    localparam logic [7:0] ADR_LVL_H  = 8'h04;
    localparam logic [7:0] ADR_DRV_L  = 8'h08;
    localparam logic [7:0] ADR_DRV_H  = 8'h0c;
    localparam logic [7:0] ADR_DSET_L = 8'h10;
    localparam logic [7:0] ADR_DSET_H = 8'h14;
    localparam logic [7:0] ADR_DCLR_L = 8'h18;
    localparam logic [7:0] ADR_DCLR_H = 8'h1c;
    localparam logic [7:0] ADR_OE_L   = 8'h20;
    localparam logic [7:0] ADR_OE_H   = 8'h24;
    localparam logic [7:0] ADR_OSET_L = 8'h28;
    localparam logic [7:0] ADR_OSET_H = 8'h2c;
    localparam logic [7:0] ADR_OCLR_L = 8'h30;
    localparam logic [7:0] ADR_OCLR_H = 8'h34;
    localparam logic [7:0] ADR_PU_L   = 8'h38;
    localparam logic [7:0] ADR_PU_H   = 8'h3c;
    localparam logic [7:0] ADR_PD_L   = 8'h40;
    localparam logic [7:0] ADR_PD_H   = 8'h44;
    localparam logic [7:0] ADR_ODRN   = 8'h48;
    localparam logic [7:0] ADR_OSRC   = 8'h4c;
    localparam logic [7:0] ADR_ALT    = 8'h50;
    localparam logic [7:0] ADR_IRQCFG = 8'h54;
    localparam logic [7:0] ADR_IRQST  = 8'h58;
    localparam logic [7:0] ADR_WSEL   = 8'h5c;
    localparam logic [7:0] ADR_WST    = 8'h60;
    localparam logic [7:0] ADR_DBG    = 8'h64;

    // irq config nibble per line: enable, edge mode, active high / rising, filter
    localparam int IC_EN             = 0;
    localparam int IC_EDGE           = 1;
    localparam int IC_POL            = 2;
    localparam int IC_FILT           = 3;

    localparam logic [16:0] RST_VEC17 = 17'h00000;
    localparam logic [15:0] RST_CFG16 = 16'h0000;

    typedef enum logic [1:0] {WR_LOAD, WR_SET, WR_CLR} gpwm_wr_op_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } gpwm_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } gpwm_wb_rsp_t;

endpackage

// ---- gpwm_port.sv ----
// 17-pin gpio port: wishbone registers, pad drive, interrupt pins, wake monitor
// assumes the whole block sits in the always-powered domain on one clock;
// rst_i is that domain's reset, so core supply loss does not touch it
//
// What this block does
// - seventeen pins, each input, output or both
// - push-pull, open-drain or open-source per pin
// - separate pull-up and pull-down enable registers
// - input registers return sampled pin levels
// - driver active only when direction bit set; alt-routed pins follow alt_oe_i
// - output registers hold the driven level
// - set writes turn written ones to one
// - clear writes turn written ones to zero
// - settings survive core supply loss
// - config register routes alternate functions to pins
// - pins 8, 14, 15, 16 are interrupts
// - per line filter, trigger and enable
// - capture 80ns unfiltered, 450ns filtered
// - outputs frozen during deep sleep
// - detect changes on monitored input pins
// - wake select picks low pins; changes wake
// - timer captures see pins without filtering
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/100ps

module gpwm_port (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // wishbone slave
    input  wire gpwm_pkg::gpwm_wb_req_t wb_req_i,
    output gpwm_pkg::gpwm_wb_rsp_t     wb_rsp_o,
    // pads
    input  wire logic [16:0]           pad_i,
    output logic      [16:0]           pad_o,
    output logic      [16:0]           pad_oe_n_o,
    output logic      [16:0]           pull_up_o,
    output logic      [16:0]           pull_down_o,
    // alternate peripheral functions
    input  wire logic [16:0]           alt_out_i,
    input  wire logic [16:0]           alt_oe_i,
    output logic      [16:0]           pin_sync_o,
    // power and events
    input  wire logic                  deep_sleep_i,
    output logic      [3:0]            ext_irq_o,
    output logic                       wake_o
);

    // ************************************************
    // bus access
    // ************************************************
    logic        ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic        wr_go;
    logic [7:0]  adr;

    assign adr   = wb_req_i.adr;
    assign wr_go = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_reg;

    function automatic logic [16:0] upd(input logic [16:0] old, input logic hi, input logic [31:0] d,
                                        input logic [3:0] sel, input gpwm_pkg::gpwm_wr_op_t op);
        logic [31:0] m32;
        logic [16:0] m;
        logic [16:0] v;
        logic [16:0] r;
        m32 = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        m   = hi ? {m32[0], 16'h0000} : {1'b0, m32[15:0]};
        v   = (hi ? {d[0], 16'h0000} : {1'b0, d[15:0]}) & m;
        case (op)
            gpwm_pkg::WR_LOAD: r = (old & ~m) | v;
            gpwm_pkg::WR_SET:  r = old | v;
            gpwm_pkg::WR_CLR:  r = old & ~v;
            default:           r = old;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] upd16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] m;
        m = {{8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (d[15:0] & m);
    endfunction

    // ************************************************
    // configuration registers
    // ************************************************
    logic [16:0] drive_reg;
    logic [16:0] oe_reg;
    logic [16:0] pu_reg;
    logic [16:0] pd_reg;
    logic [16:0] odrn_reg;
    logic [16:0] osrc_reg;
    logic [16:0] alt_reg;
    logic [15:0] irq_cfg_reg;
    logic [15:0] wake_sel_reg;
    logic [31:0] dbg_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drive_reg <= gpwm_pkg::RST_VEC17;
        end else if (wr_go) begin
            case (adr)
                gpwm_pkg::ADR_DRV_L:  drive_reg <= upd(drive_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_DRV_H:  drive_reg <= upd(drive_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_DSET_L: drive_reg <= upd(drive_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_SET);
                gpwm_pkg::ADR_DSET_H: drive_reg <= upd(drive_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_SET);
                gpwm_pkg::ADR_DCLR_L: drive_reg <= upd(drive_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_CLR);
                gpwm_pkg::ADR_DCLR_H: drive_reg <= upd(drive_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_CLR);
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            oe_reg <= gpwm_pkg::RST_VEC17;
        end else if (wr_go) begin
            case (adr)
                gpwm_pkg::ADR_OE_L:   oe_reg <= upd(oe_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_OE_H:   oe_reg <= upd(oe_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_OSET_L: oe_reg <= upd(oe_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_SET);
                gpwm_pkg::ADR_OSET_H: oe_reg <= upd(oe_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_SET);
                gpwm_pkg::ADR_OCLR_L: oe_reg <= upd(oe_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_CLR);
                gpwm_pkg::ADR_OCLR_H: oe_reg <= upd(oe_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_CLR);
                default: begin
                end
            endcase
        end
    end

    // pulls, drive style, routing, irq and wake setup
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pu_reg       <= gpwm_pkg::RST_VEC17;
            pd_reg       <= gpwm_pkg::RST_VEC17;
            odrn_reg     <= gpwm_pkg::RST_VEC17;
            osrc_reg     <= gpwm_pkg::RST_VEC17;
            alt_reg      <= gpwm_pkg::RST_VEC17;
            irq_cfg_reg  <= gpwm_pkg::RST_CFG16;
            wake_sel_reg <= gpwm_pkg::RST_CFG16;
            dbg_reg      <= 32'h00000000;
        end else if (wr_go) begin
            case (adr)
                gpwm_pkg::ADR_PU_L:   pu_reg       <= upd(pu_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_PU_H:   pu_reg       <= upd(pu_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_PD_L:   pd_reg       <= upd(pd_reg, 1'b0, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_PD_H:   pd_reg       <= upd(pd_reg, 1'b1, wb_req_i.dat, wb_req_i.sel, gpwm_pkg::WR_LOAD);
                gpwm_pkg::ADR_ODRN:   odrn_reg     <= wb_req_i.dat[16:0];
                gpwm_pkg::ADR_OSRC:   osrc_reg     <= wb_req_i.dat[16:0];
                gpwm_pkg::ADR_ALT:    alt_reg      <= wb_req_i.dat[16:0];
                gpwm_pkg::ADR_IRQCFG: irq_cfg_reg  <= upd16(irq_cfg_reg, wb_req_i.dat, wb_req_i.sel);
                gpwm_pkg::ADR_WSEL:   wake_sel_reg <= upd16(wake_sel_reg, wb_req_i.dat, wb_req_i.sel);
                gpwm_pkg::ADR_DBG:    dbg_reg      <= wb_req_i.dat;
                default: begin
                end
            endcase
        end
    end

    // ************************************************
    // pin sampling
    // ************************************************
    logic [16:0] pin_meta_reg;
    logic [16:0] pin_sync_reg;
    logic [15:0] pin_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= gpwm_pkg::RST_VEC17;
            pin_sync_reg <= gpwm_pkg::RST_VEC17;
            pin_prev_reg <= gpwm_pkg::RST_CFG16;
        end else begin
            pin_meta_reg <= pad_i;
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg[15:0];
        end
    end

    // timer captures take the plain sampled level, no filter or trigger options
    assign pin_sync_o  = pin_sync_reg;
    assign pull_up_o   = pu_reg;
    assign pull_down_o = pd_reg;

    // ************************************************
    // pad drive and sleep freeze
    // ************************************************
    logic [16:0] lvl;
    logic [16:0] en;
    logic [16:0] act;
    logic [16:0] pad_reg;
    logic [16:0] oe_n_reg;

    assign lvl = (alt_reg & alt_out_i) | (~alt_reg & drive_reg);
    assign en  = (alt_reg & alt_oe_i) | (~alt_reg & oe_reg);
    // open-drain wins if both styles are set, so a pin never fights a wired bus high
    assign act = en & ((odrn_reg & ~lvl) | (~odrn_reg & osrc_reg & lvl) | (~odrn_reg & ~osrc_reg));

    // holding the flops during sleep keeps pads at their entry level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_reg  <= gpwm_pkg::RST_VEC17;
            oe_n_reg <= ~gpwm_pkg::RST_VEC17;
        end else if (!deep_sleep_i) begin
            pad_reg  <= lvl;
            oe_n_reg <= ~act;
        end
    end

    assign pad_o      = pad_reg;
    assign pad_oe_n_o = oe_n_reg;

    // ************************************************
    // external interrupt lines
    // ************************************************
    logic [3:0]      irq_raw;
    logic [3:0]      filt_lvl_reg;
    logic [5:0]      filt_cnt_reg [4];
    logic [3:0]      src_prev_reg;
    logic [3:0]      src;
    logic [3:0]      hit;
    logic [3:0]      irq_flag_reg;
    logic            irq_clr;

    assign irq_raw = {pin_sync_reg[gpwm_pkg::IRQ_PIN_D], pin_sync_reg[gpwm_pkg::IRQ_PIN_C],
                      pin_sync_reg[gpwm_pkg::IRQ_PIN_B], pin_sync_reg[gpwm_pkg::IRQ_PIN_A]};

    // filtered level only follows after the input held its new value long enough
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_lvl_reg <= 4'h0;
            for (int i = 0; i < gpwm_pkg::NIRQ; i++) begin
                filt_cnt_reg[i] <= 6'h00;
            end
        end else begin
            for (int i = 0; i < gpwm_pkg::NIRQ; i++) begin
                if (irq_raw[i] == filt_lvl_reg[i]) begin
                    filt_cnt_reg[i] <= 6'h00;
                end else if (filt_cnt_reg[i] == gpwm_pkg::FILT_LAST) begin
                    filt_lvl_reg[i] <= irq_raw[i];
                    filt_cnt_reg[i] <= 6'h00;
                end else begin
                    filt_cnt_reg[i] <= filt_cnt_reg[i] + 6'h01;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < gpwm_pkg::NIRQ; i++) begin
            src[i] = irq_cfg_reg[4*i+gpwm_pkg::IC_FILT] ? filt_lvl_reg[i] : irq_raw[i];
            hit[i] = irq_cfg_reg[4*i+gpwm_pkg::IC_EDGE]
                   ? (src[i] != src_prev_reg[i]) && (src[i] == irq_cfg_reg[4*i+gpwm_pkg::IC_POL])
                   : (src[i] == irq_cfg_reg[4*i+gpwm_pkg::IC_POL]);
        end
    end

    assign irq_clr = wr_go && adr == gpwm_pkg::ADR_IRQST && wb_req_i.sel[0];

    // a hit in the clearing cycle survives the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev_reg <= 4'h0;
            irq_flag_reg <= 4'h0;
        end else begin
            src_prev_reg <= src;
            irq_flag_reg <= (irq_flag_reg & ~(irq_clr ? wb_req_i.dat[3:0] : 4'h0)) | hit;
        end
    end

    always_comb begin
        for (int i = 0; i < gpwm_pkg::NIRQ; i++) begin
            ext_irq_o[i] = irq_flag_reg[i] & irq_cfg_reg[4*i+gpwm_pkg::IC_EN];
        end
    end

    // ************************************************
    // wake monitor, never gated by sleep
    // ************************************************
    logic [15:0] wake_st_reg;
    logic [15:0] chg;
    logic        wake_clr;

    assign chg      = (pin_sync_reg[15:0] ^ pin_prev_reg) & wake_sel_reg;
    assign wake_clr = wr_go && adr == gpwm_pkg::ADR_WST;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_st_reg <= gpwm_pkg::RST_CFG16;
        end else begin
            wake_st_reg <= (wake_st_reg & ~(wake_clr ? wb_req_i.dat[15:0] : 16'h0000)) | chg;
        end
    end

    assign wake_o = |wake_st_reg;

    // ************************************************
    // read mux and acknowledge
    // ************************************************
    always_comb begin
        case (adr)
            gpwm_pkg::ADR_LVL_L:  rdat_next = {16'h0000, pin_sync_reg[15:0]};
            gpwm_pkg::ADR_LVL_H:  rdat_next = {31'h00000000, pin_sync_reg[16]};
            gpwm_pkg::ADR_DRV_L, gpwm_pkg::ADR_DSET_L, gpwm_pkg::ADR_DCLR_L:
                                  rdat_next = {16'h0000, drive_reg[15:0]};
            gpwm_pkg::ADR_DRV_H, gpwm_pkg::ADR_DSET_H, gpwm_pkg::ADR_DCLR_H:
                                  rdat_next = {31'h00000000, drive_reg[16]};
            gpwm_pkg::ADR_OE_L, gpwm_pkg::ADR_OSET_L, gpwm_pkg::ADR_OCLR_L:
                                  rdat_next = {16'h0000, oe_reg[15:0]};
            gpwm_pkg::ADR_OE_H, gpwm_pkg::ADR_OSET_H, gpwm_pkg::ADR_OCLR_H:
                                  rdat_next = {31'h00000000, oe_reg[16]};
            gpwm_pkg::ADR_PU_L:   rdat_next = {16'h0000, pu_reg[15:0]};
            gpwm_pkg::ADR_PU_H:   rdat_next = {31'h00000000, pu_reg[16]};
            gpwm_pkg::ADR_PD_L:   rdat_next = {16'h0000, pd_reg[15:0]};
            gpwm_pkg::ADR_PD_H:   rdat_next = {31'h00000000, pd_reg[16]};
            gpwm_pkg::ADR_ODRN:   rdat_next = {15'h0000, odrn_reg};
            gpwm_pkg::ADR_OSRC:   rdat_next = {15'h0000, osrc_reg};
            gpwm_pkg::ADR_ALT:    rdat_next = {15'h0000, alt_reg};
            gpwm_pkg::ADR_IRQCFG: rdat_next = {16'h0000, irq_cfg_reg};
            gpwm_pkg::ADR_IRQST:  rdat_next = {28'h0000000, irq_flag_reg};
            gpwm_pkg::ADR_WSEL:   rdat_next = {16'h0000, wake_sel_reg};
            gpwm_pkg::ADR_WST:    rdat_next = {16'h0000, wake_st_reg};
            gpwm_pkg::ADR_DBG:    rdat_next = dbg_reg;
            default:              rdat_next = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            ack_reg  <= wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_rsp_o.ack = ack_reg;
    assign wb_rsp_o.dat = rdat_reg;

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_set_ones: assert property (wr_go && adr == gpwm_pkg::ADR_DSET_L && wb_req_i.sel == 4'hf
        |=> (drive_reg[15:0] & $past(wb_req_i.dat[15:0])) == $past(wb_req_i.dat[15:0]))
        else $error("set write left a bit low");
    chk_clr_zeros: assert property (wr_go && adr == gpwm_pkg::ADR_OCLR_L && wb_req_i.sel == 4'hf
        |=> (oe_reg[15:0] & $past(wb_req_i.dat[15:0])) == 16'h0000)
        else $error("clear write left a bit high");
    chk_zero_keeps: assert property (wr_go && adr == gpwm_pkg::ADR_DSET_L && wb_req_i.sel == 4'hf
        |=> (drive_reg[15:0] & ~$past(wb_req_i.dat[15:0])) == ($past(drive_reg[15:0]) & ~$past(wb_req_i.dat[15:0])))
        else $error("set write disturbed an unwritten bit");
    chk_dir_gate: assert property (!$past(deep_sleep_i) && $past(alt_reg) == 17'h00000
        |-> (~pad_oe_n_o & ~$past(oe_reg)) == 17'h00000)
        else $error("pad driven with direction bit clear");
    chk_drain_low: assert property (!$past(deep_sleep_i) |-> (~pad_oe_n_o & $past(odrn_reg) & pad_o) == 17'h00000)
        else $error("open-drain pin driven high");
    chk_sleep_hold: assert property (deep_sleep_i ##1 deep_sleep_i |-> $stable(pad_o) && $stable(pad_oe_n_o))
        else $error("pad changed during deep sleep");
    chk_wake_change: assert property (chg != 16'h0000 |=> wake_o && (wake_st_reg & $past(chg)) == $past(chg))
        else $error("monitored change gave no wake event");
    chk_filter_span: assert property ($changed(filt_lvl_reg[0]) |-> $past(filt_cnt_reg[0]) == gpwm_pkg::FILT_LAST)
        else $error("filtered level moved before its hold time");
    chk_edge_catch: assert property (irq_cfg_reg[3:0] == 4'h7 && $rose(irq_raw[0]) ##1 1'b1
        |-> ext_irq_o[0])
        else $error("rising edge on line a not captured");
    chk_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("acknowledge held past one cycle");

    cov_set_write: cover property (wr_go && adr == gpwm_pkg::ADR_DSET_H);
    cov_sleep_entry: cover property (!deep_sleep_i ##1 deep_sleep_i ##1 deep_sleep_i);
    cov_wake_event: cover property ($rose(wake_o));
    cov_filtered_irq: cover property (irq_cfg_reg[7] && $rose(ext_irq_o[1]));

endmodule

// ---- gpwm_pads.sv ----
// pin-side model: external circuits, pulls and floating pins
// assumes one clock; undriven unpulled pins toggle so no stale level reads back
`timescale 1ns/100ps

module gpwm_pads (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // from the port
    input  wire logic [16:0] drv_i,
    input  wire logic [16:0] oe_n_i,
    input  wire logic [16:0] pu_i,
    input  wire logic [16:0] pd_i,
    // external drivers
    input  wire logic [16:0] ext_val_i,
    input  wire logic [16:0] ext_en_i,
    // resolved pin levels
    output logic      [16:0] lvl_o
);
    logic tog_reg;

    always_ff @(posedge clk_i) begin
        tog_reg <= rst_i ? 1'b0 : ~tog_reg;
    end

    always_comb begin
        for (int k = 0; k < 17; k++) begin
            if (!oe_n_i[k]) lvl_o[k] = drv_i[k];
            else if (ext_en_i[k]) lvl_o[k] = ext_val_i[k];
            else if (pu_i[k]) lvl_o[k] = 1'b1;
            else if (pd_i[k]) lvl_o[k] = 1'b0;
            else lvl_o[k] = tog_reg ^ k[0];
        end
    end
endmodule

// ---- gpwm_tb.sv ----
// self-checking bench: wishbone register calls against the gpio port and pad model
// assumes the design answers each request once, releasing after every ack
`timescale 1ns/100ps

module tb;
    logic                   clk_i   = 1'b0;
    logic                   rst_i   = 1'b1;
    gpwm_pkg::gpwm_wb_req_t req     = '0;
    gpwm_pkg::gpwm_wb_rsp_t rsp;
    logic [16:0]            pad_i, pad_o, oe_n, pu, pd, sync;
    logic [16:0]            alt_out = 17'h00008;
    logic [16:0]            alt_oe  = 17'h00008;
    logic [16:0]            ext_val = '0;
    logic [16:0]            ext_en  = '0;
    logic                   sleep   = 1'b0;
    logic                   wake;
    logic [3:0]             irq;
    logic [31:0]            q;
    int                     n_fail  = 0;
    int                     num_checks = 0;

    always #5 clk_i = ~clk_i;

    gpwm_port gpwm_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .pad_i(pad_i),
        .pad_o(pad_o), .pad_oe_n_o(oe_n), .pull_up_o(pu), .pull_down_o(pd), .alt_out_i(alt_out),
        .alt_oe_i(alt_oe), .pin_sync_o(sync), .deep_sleep_i(sleep), .ext_irq_o(irq), .wake_o(wake));
    gpwm_pads gpwm_pads_i (.clk_i(clk_i), .rst_i(rst_i), .drv_i(pad_o), .oe_n_i(oe_n), .pu_i(pu),
        .pd_i(pd), .ext_val_i(ext_val), .ext_en_i(ext_en), .lvl_o(pad_i));

    // ****************
    // tasks
    // ****************
    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // waits on ack, then checks it came one cycle after the first edge; only the watchdog ends a hung wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
        @(posedge clk_i);
        while (rsp.ack !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        q = rsp.dat;
        req <= '0;
        @(posedge clk_i);
        chk("ack wait", 32'h1, 32'(n));
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q & m);
    endtask

    // covers the two-flop pin sync plus one registered stage
    task automatic settle;
        repeat (4) @(posedge clk_i);
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("oe_n", 32'h0001ffff, 32'(oe_n));
        rd(8'h54, 32'h0);
        wr(8'h08, 32'h0000a5a5);
        wr(8'h28, 32'h000000ff);
        wr(8'h38, 32'h0000ff00);
        settle();
        rd(8'h00, 32'h0000ffa5);
        wr(8'h10, 32'h00000f00);
        wr(8'h18, 32'h00000005);
        rd(8'h08, 32'h0000afa0);
        wr(8'h30, 32'h000000f0);
        wr(8'h28, 32'h00000000);
        rd(8'h20, 32'h0000000f);
        wr(8'h2c, 32'h00000001);
        wr(8'h14, 32'h00000001);
        settle();
        rd(8'h04, 32'h00000001);
        wr(8'h4c, 32'h00000002);
        wr(8'h38, 32'h0000ff02);
        settle();
        rd(8'h00, 32'h0000ff02, 32'h0000ff0f);
        // open-drain pin 16 at level one lets go, so the pull-down shows
        wr(8'h44, 32'h00000001);
        wr(8'h48, 32'h00010001);
        settle();
        rd(8'h04, 32'h00000000);
        rd(8'h0c, 32'h00000001);
        wr(8'h48, 32'h00000000);
        settle();
        rd(8'h04, 32'h00000001);
        wr(8'h50, 32'h00000008);
        settle();
        chk("alt pin", 32'h0, 32'({oe_n[3], ~pad_o[3]}));
        // outputs must hold while asleep although the register moves
        sleep <= 1'b1;
        wr(8'h10, 32'h00000001);
        wr(8'h5c, 32'h00000100);
        ext_en[8] <= 1'b1;
        settle();
        chk("sleep pad", 32'h0, 32'(pad_o[0]));
        chk("wake", 32'h1, 32'(wake));
        rd(8'h60, 32'h00000100);
        wr(8'h60, 32'h00000100);
        rd(8'h60, 32'h0);
        sleep <= 1'b0;
        wr(8'h54, 32'h000007f7);
        // flags latched while lines sat in the reset level-low mode; clear them first
        wr(8'h58, 32'h0000000f);
        ext_val[8] <= 1'b1;
        settle();
        chk("pad awake", 32'h1, 32'(pad_o[0]));
        chk("irq", 32'h1, 32'(irq));
        wr(8'h58, 32'h00000001);
        rd(8'h58, 32'h0);
        ext_en[15:14] <= 2'b11;
        repeat (60) @(posedge clk_i);
        ext_val[15:14] <= 2'b11;
        repeat (8) @(posedge clk_i);
        ext_val[15:14] <= 2'b00;
        repeat (60) @(posedge clk_i);
        chk("irq short", 32'h4, 32'(irq));
        ext_val[14] <= 1'b1;
        repeat (60) @(posedge clk_i);
        chk("irq long", 32'h6, 32'(irq));
        chk("sync", 32'h1, 32'(sync[8]));
        rd(8'h80, 32'h0);
        rd(8'h64, 32'h0);
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end
endmodule
